// ==== include/crsc_regs.svh ====
// register map, field positions and timing counts of the chip reset source control block
// assumes a 250 MHz oscillator clock and byte addresses on a 32-bit AXI4-Lite bus
`ifndef CRSC_REGS_SVH
`define CRSC_REGS_SVH

`define CRSC_ADDR_FLAGS 32'he01fc180
`define CRSC_ADDR_IRQ_STAT 32'he01fc184
`define CRSC_ADDR_IRQ_MASK 32'he01fc188

`define CRSC_BIT_POR 0
`define CRSC_BIT_PIN 1
`define CRSC_BIT_WDT 2
`define CRSC_FLAGS_POR_VAL 3'h1
`define CRSC_IRQ_BIT_REL 0
`define CRSC_IRQ_BIT_PIN 1
`define CRSC_IRQ_BIT_WDT 2
`define CRSC_IRQ_W 3

`define CRSC_BOOT_ADDR 32'h0000_0000
`define CRSC_CLK_MHZ 250
`define CRSC_FILT_NS 100
`define CRSC_FILT_CYC ((`CRSC_FILT_NS * `CRSC_CLK_MHZ) / 1000)
`define CRSC_FILT_W 8
`define CRSC_WAKE_CYC 4096
`define CRSC_WAKE_W 13
`define CRSC_CFG_W 4

`define CRSC_RESP_OKAY 2'h0
`define CRSC_RESP_DECERR 2'h3

`endif

// ==== include/crsc_pkg.sv ====
// types shared by the chip reset source control block
// assumes nothing of its surroundings
`default_nettype none
package crsc_pkg;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_WAKE,
    ST_INIT,
    ST_RUN
  } crsc_state_t;

  typedef struct packed {
    logic wdt;
    logic pin;
    logic por;
  } crsc_flags_t;

endpackage
`default_nettype wire

// ==== src/crsc_reset_ctrl.sv ====
// chip reset source control: merges the filtered reset pin and the watchdog into one chip reset,
// holds it through the oscillator wake-up count, initialisation and flash settling,
// and records the cause in a write-one-to-clear flag register over AXI4-Lite.
// assumes aresetn is the power-on reset and the watchdog, init and flash signals share aclk.
//
// Register access over AXI4-Lite was decided locally.
`include "crsc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module crsc_reset_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic reset_pin_n,
  input wire logic osc_running,
  input wire logic [`CRSC_CFG_W-1:0] cfg_pins,
  input wire logic wdt_timeout,
  input wire logic watchdog_reset_enable,
  input wire logic init_done,
  input wire logic flash_busy,
  input wire logic flash_hv_settled,
  output logic chip_reset_n,
  output logic init_start,
  output logic flash_abort,
  output logic [31:0] boot_addr,
  output logic [`CRSC_CFG_W-1:0] cfg_latched,
  output logic irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // three-stage synchronisers for pins; a change counts once stages two and three agree
  logic [2:0] pin_sync_r;
  logic [2:0] osc_sync_r;
  logic [`CRSC_CFG_W-1:0] cfg_s1_r, cfg_s2_r, cfg_s3_r;
  logic pin_high_r;
  logic osc_up_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_r <= 3'h7;
      osc_sync_r <= 3'h0;
      pin_high_r <= 1'b1;
      osc_up_r <= 1'b0;
    end else if (clk_en) begin
      pin_sync_r <= {pin_sync_r[1:0], reset_pin_n};
      osc_sync_r <= {osc_sync_r[1:0], osc_running};
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_high_r <= pin_sync_r[2];
      end
      if (osc_sync_r[1] == osc_sync_r[2]) begin
        osc_up_r <= osc_sync_r[2];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_s1_r <= '0;
      cfg_s2_r <= '0;
      cfg_s3_r <= '0;
    end else if (clk_en) begin
      cfg_s1_r <= cfg_pins;
      cfg_s2_r <= cfg_s1_r;
      cfg_s3_r <= cfg_s2_r;
    end
  end

  // glitch filter: the pin counts as asserted only after a run of low samples
  logic [`CRSC_FILT_W-1:0] filt_cnt_r;
  logic pin_rst_r;
  wire filt_full = (filt_cnt_r == `CRSC_FILT_W'(`CRSC_FILT_CYC));
  wire [`CRSC_FILT_W-1:0] filt_cnt_nxt = pin_high_r ? '0 : (filt_full ? filt_cnt_r : filt_cnt_r + 1'b1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_cnt_r <= '0;
      pin_rst_r <= 1'b0;
    end else if (clk_en) begin
      filt_cnt_r <= filt_cnt_nxt;
      pin_rst_r <= ~pin_high_r & filt_full;
    end
  end

  // reset events
  logic pin_rst_q_r;
  wire pin_evt = pin_rst_r & ~pin_rst_q_r;
  wire wdt_evt = wdt_timeout & watchdog_reset_enable;
  wire reset_req = pin_rst_r | wdt_evt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_rst_q_r <= 1'b0;
    end else if (clk_en) begin
      pin_rst_q_r <= pin_rst_r;
    end
  end

  // configuration latch follows the pin only while it holds reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_latched <= '0;
    end else if (clk_en && pin_rst_r && (cfg_s2_r == cfg_s3_r)) begin
      cfg_latched <= cfg_s3_r;
    end
  end

  // flash hold: a reset that hits a program or erase aborts it and waits for settling
  logic flash_hold_r;
  wire flash_hit = reset_req & flash_busy;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_hold_r <= 1'b0;
      flash_abort <= 1'b0;
    end else if (clk_en) begin
      flash_abort <= flash_hit;
      if (flash_hit) begin
        flash_hold_r <= 1'b1;
      end else if (flash_hv_settled) begin
        flash_hold_r <= 1'b0;
      end
    end
  end

  // reset sequencer
  crsc_pkg::crsc_state_t state_r, state_nxt;
  logic [`CRSC_WAKE_W-1:0] wake_cnt_r, wake_cnt_nxt;
  wire wake_done = (wake_cnt_r == `CRSC_WAKE_W'(`CRSC_WAKE_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    wake_cnt_nxt = wake_cnt_r;
    case (state_r)
      crsc_pkg::ST_HOLD: begin
        wake_cnt_nxt = '0;
        if (!pin_rst_r && pin_high_r && osc_up_r) begin
          state_nxt = crsc_pkg::ST_WAKE;
        end
      end
      crsc_pkg::ST_WAKE: begin
        wake_cnt_nxt = wake_cnt_r + 1'b1;
        if (wake_done) begin
          state_nxt = crsc_pkg::ST_INIT;
        end
      end
      crsc_pkg::ST_INIT: begin
        if (init_done && !flash_hold_r && pin_high_r) begin
          state_nxt = crsc_pkg::ST_RUN;
        end
      end
      crsc_pkg::ST_RUN: begin
        state_nxt = crsc_pkg::ST_RUN;
      end
      default: begin
        state_nxt = crsc_pkg::ST_HOLD;
      end
    endcase
    // any reset or a lost oscillator restarts the wake-up timer
    if (reset_req || !osc_up_r) begin
      state_nxt = crsc_pkg::ST_HOLD;
      wake_cnt_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= crsc_pkg::ST_HOLD;
      wake_cnt_r <= '0;
      chip_reset_n <= 1'b0;
      init_start <= 1'b0;
      boot_addr <= `CRSC_BOOT_ADDR;
    end else if (clk_en) begin
      state_r <= state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      chip_reset_n <= (state_nxt == crsc_pkg::ST_RUN);
      init_start <= (state_nxt == crsc_pkg::ST_INIT);
      boot_addr <= `CRSC_BOOT_ADDR;
    end
  end

  // cause flags; the set always wins over a clearing write
  crsc_pkg::crsc_flags_t flags_r, flags_nxt;
  logic [`CRSC_IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic [`CRSC_IRQ_W-1:0] irq_set;

  // axi write path
  logic aw_hold_r, w_hold_r;
  logic [31:0] awaddr_r, wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic bvalid_r;
  wire wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_flags = (awaddr_r == `CRSC_ADDR_FLAGS);
  wire wr_stat = (awaddr_r == `CRSC_ADDR_IRQ_STAT);
  wire wr_mask = (awaddr_r == `CRSC_ADDR_IRQ_MASK);
  wire wr_hit = wr_flags | wr_stat | wr_mask;
  wire wr_lane0 = wr_go & wstrb_r[0];
  wire [`CRSC_IRQ_W-1:0] wr_bits = wdata_r[`CRSC_IRQ_W-1:0];
  wire [`CRSC_IRQ_W-1:0] clr_flags = (wr_lane0 & wr_flags) ? wr_bits : '0;
  wire [`CRSC_IRQ_W-1:0] clr_stat = (wr_lane0 & wr_stat) ? wr_bits : '0;

  assign s_axi_awready = ~aw_hold_r;
  assign s_axi_wready = ~w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `CRSC_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `CRSC_RESP_OKAY : `CRSC_RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // flag update: por bit only ever cleared by software, pin and watchdog set by their events and held until written clear; a pin reset also clears the watchdog bit
  always_comb begin
    flags_nxt.por = flags_r.por & ~clr_flags[`CRSC_BIT_POR];
    flags_nxt.pin = pin_evt | (flags_r.pin & ~clr_flags[`CRSC_BIT_PIN]);
    flags_nxt.wdt = wdt_evt | (flags_r.wdt & ~clr_flags[`CRSC_BIT_WDT] & ~pin_evt);
  end

  assign irq_set[`CRSC_IRQ_BIT_REL] = (state_nxt == crsc_pkg::ST_RUN) & ~chip_reset_n;
  assign irq_set[`CRSC_IRQ_BIT_PIN] = pin_evt;
  assign irq_set[`CRSC_IRQ_BIT_WDT] = wdt_evt;
  assign irq_stat_nxt = irq_set | (irq_stat_r & ~clr_stat);
  assign irq_mask_nxt = (wr_lane0 & wr_mask) ? wr_bits : irq_mask_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= `CRSC_FLAGS_POR_VAL;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      flags_r <= flags_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // axi read path; one read in flight, answered the cycle after the address is taken
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire rd_flags = (s_axi_araddr == `CRSC_ADDR_FLAGS);
  wire rd_stat = (s_axi_araddr == `CRSC_ADDR_IRQ_STAT);
  wire rd_mask = (s_axi_araddr == `CRSC_ADDR_IRQ_MASK);
  wire rd_hit = rd_flags | rd_stat | rd_mask;
  wire [`CRSC_IRQ_W-1:0] rd_bits = rd_flags ? flags_r : (rd_stat ? irq_stat_r : (rd_mask ? irq_mask_r : '0));

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `CRSC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rdata_r <= {{(32 - `CRSC_IRQ_W){1'b0}}, rd_bits};
        rresp_r <= rd_hit ? `CRSC_RESP_OKAY : `CRSC_RESP_DECERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // the board-side timing of the pin is not checked here; a too-short pulse is just filtered

endmodule
`default_nettype wire

// ==== testbench/crsc_board_model.sv ====
// board reset circuit: crystal start-up and reset pin driver
// assumes the bench switches the oscillator and requests the pin
`timescale 1ns/1ps
`default_nettype none
module crsc_board_model #(parameter int STABLE_CYC = 64) (
  input wire logic aclk,
  input wire logic osc_on,
  input wire logic hold_n,
  output logic osc_running,
  output logic reset_pin_n
);
  int cnt = 0;
  always @(posedge aclk) cnt <= osc_on ? ((cnt < STABLE_CYC) ? cnt + 1 : cnt) : 0;
  assign osc_running = osc_on;
  // pin kept low until the crystal settles; hold time scaled down
  assign reset_pin_n = hold_n && (cnt >= STABLE_CYC);
endmodule
`default_nettype wire

// ==== testbench/crsc_reset_ctrl_asserts.sv ====
// checker on the reset source control ports
// assumes clk_en is held high
`include "crsc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module crsc_reset_ctrl_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin_n,
  input wire logic osc_running,
  input wire logic wdt_timeout,
  input wire logic watchdog_reset_enable,
  input wire logic init_done,
  input wire logic flash_busy,
  input wire logic chip_reset_n,
  input wire logic init_start,
  input wire logic flash_abort,
  input wire logic [31:0] boot_addr,
  input wire logic [`CRSC_CFG_W-1:0] cfg_latched
);
  logic [12:0] up_r;
  logic [12:0] up_nxt;
  // raw inputs lead the synchronisers, so this count lags the design's only after a pin or oscillator glitch that the design filters out
  assign up_nxt = (!osc_running || !reset_pin_n || (wdt_timeout && watchdog_reset_enable)) ? 13'h0 :
    (&up_r) ? up_r : up_r + 13'h1;
  always_ff @(posedge aclk) begin
    if (!aresetn) up_r <= 13'h0;
    else up_r <= up_nxt;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  boot_zero_a: assert property (chip_reset_n |-> boot_addr == 32'h0)
    else $error("boot address not zero");
  init_hold_a: assert property (init_start |-> !chip_reset_n)
    else $error("init while running");
  release_cause_a: assert property ($rose(chip_reset_n) |-> $past(init_done) && reset_pin_n && osc_running)
    else $error("early release");
  wake_count_a: assert property ($rose(init_start) |-> up_r >= 13'h1000)
    else $error("short wake count");
  abort_cause_a: assert property (flash_abort |-> $past(flash_busy))
    else $error("stray flash abort");
  cfg_keep_a: assert property (!$stable(cfg_latched) |-> !chip_reset_n)
    else $error("straps moved while running");
  wdt_off_a: assert property (chip_reset_n && wdt_timeout && !watchdog_reset_enable |=> chip_reset_n)
    else $error("disabled watchdog reset");
  wdt_on_a: assert property (chip_reset_n && wdt_timeout && watchdog_reset_enable |-> ##[1:2] !chip_reset_n)
    else $error("watchdog reset missed");
endmodule
bind crsc_reset_ctrl crsc_reset_ctrl_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
  .osc_running(osc_running), .wdt_timeout(wdt_timeout), .watchdog_reset_enable(watchdog_reset_enable),
  .init_done(init_done), .flash_busy(flash_busy), .chip_reset_n(chip_reset_n), .init_start(init_start),
  .flash_abort(flash_abort), .boot_addr(boot_addr), .cfg_latched(cfg_latched));
`default_nettype wire

// ==== testbench/tb.sv ====
// bench for the reset source control block
// assumes the board model and the bound checker
`include "crsc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, osc_on = 1'b0, hold_n = 1'b0;
  logic reset_pin_n, osc_running, chip_reset_n, init_start, flash_abort, irq;
  logic wdt = 1'b0, wdt_en = 1'b0, init_done = 1'b0, busy = 1'b0, hv_ok = 1'b1, abort_seen = 1'b0;
  logic [3:0] cfg = 4'h5, strb = 4'hf;
  logic [3:0] cfg_q;
  logic [31:0] boot_addr, awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r, b;
  int mismatches = 0, n_tests = 0, cyc = 0;
  localparam logic [31:0] FL = `CRSC_ADDR_FLAGS;
  always #2 aclk = ~aclk;
  crsc_board_model #(.STABLE_CYC(64)) board (.aclk(aclk), .osc_on(osc_on), .hold_n(hold_n),
    .osc_running(osc_running), .reset_pin_n(reset_pin_n));
  crsc_reset_ctrl uut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .reset_pin_n(reset_pin_n),
    .osc_running(osc_running), .cfg_pins(cfg), .wdt_timeout(wdt), .watchdog_reset_enable(wdt_en),
    .init_done(init_done), .flash_busy(busy), .flash_hv_settled(hv_ok), .chip_reset_n(chip_reset_n),
    .init_start(init_start), .flash_abort(flash_abort), .boot_addr(boot_addr), .cfg_latched(cfg_q),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // init finishes one cycle after it is allowed
  always @(posedge aclk) begin
    init_done <= init_start;
    if (flash_abort) abort_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    b = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    axr(a, d, r);
    chk("register", d, e);
    chk("read response", {30'h0, r}, {30'h0, `CRSC_RESP_OKAY});
  endtask
  task automatic wait_run();
    do @(posedge aclk); while (chip_reset_n !== 1'b1);
  endtask
  task automatic pulse_wdt();
    wdt <= 1'b1;
    @(posedge aclk);
    wdt <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    osc_on <= 1'b1;
    repeat (100) @(posedge aclk);
    hold_n <= 1'b1;
    wait_run();
    chk("boot address", boot_addr, 32'h0);
    chk("straps", {28'h0, cfg_q}, 32'h5);
    rdchk(FL, 32'h3);
    axw(FL, 32'h0);
    rdchk(FL, 32'h3);
    axw(FL, 32'h2);
    rdchk(FL, 32'h1);
    // glitch shorter than the filter, then a timeout with its reset disabled
    hold_n <= 1'b0;
    repeat (10) @(posedge aclk);
    hold_n <= 1'b1;
    pulse_wdt();
    repeat (40) @(posedge aclk);
    chk("running", {31'h0, chip_reset_n}, 32'h1);
    rdchk(FL, 32'h1);
    cfg <= 4'ha;
    wdt_en <= 1'b1;
    pulse_wdt();
    repeat (3) @(posedge aclk);
    chk("watchdog reset", {31'h0, chip_reset_n}, 32'h0);
    wait_run();
    chk("straps", {28'h0, cfg_q}, 32'h5);
    rdchk(FL, 32'h5);
    // pin reset of 300 ns hitting a flash erase whose voltages settle late
    busy <= 1'b1;
    hv_ok <= 1'b0;
    hold_n <= 1'b0;
    repeat (75) @(posedge aclk);
    hold_n <= 1'b1;
    busy <= 1'b0;
    repeat (6000) @(posedge aclk);
    chk("flash hold", {31'h0, chip_reset_n}, 32'h0);
    chk("flash abort", {31'h0, abort_seen}, 32'h1);
    hv_ok <= 1'b1;
    wait_run();
    chk("straps", {28'h0, cfg_q}, 32'h0000000a);
    rdchk(FL, 32'h3);
    // watchdog reset whose flag is written clear in the very cycle it is set
    cfg <= 4'h5;
    fork
      axw(FL, 32'h4);
      begin
        repeat (2) @(posedge aclk);
        wdt <= 1'b1;
        @(posedge aclk);
        wdt <= 1'b0;
      end
    join
    wait_run();
    chk("straps", {28'h0, cfg_q}, 32'h0000000a);
    rdchk(FL, 32'h7);
    chk("irq", {31'h0, irq}, 32'h0);
    axw(`CRSC_ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, irq}, 32'h1);
    axw(`CRSC_ADDR_IRQ_STAT, 32'h7);
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, irq}, 32'h0);
    rdchk(`CRSC_ADDR_IRQ_STAT, 32'h0);
    axr(32'he01fc18c, d, r);
    chk("response", {30'h0, r}, {30'h0, `CRSC_RESP_DECERR});
    axw(32'he01fc18c, 32'h7);
    chk("write response", {30'h0, b}, {30'h0, `CRSC_RESP_DECERR});
    strb <= 4'he;
    axw(FL, 32'h7);
    strb <= 4'hf;
    rdchk(FL, 32'h7);
    axw(FL, 32'h7);
    chk("write response", {30'h0, b}, {30'h0, `CRSC_RESP_OKAY});
    rdchk(FL, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
